// file: rtl/cur_out_defs.svh
`ifndef CUR_OUT_DEFS_SVH
`define CUR_OUT_DEFS_SVH

// word indices; byte address is four times the index
`define IDX_CHAN_LAST 4'hB
`define IDX_OPEN_LOOP 4'hC
`define IDX_CFG_STAT 4'hD
`define IDX_SMART_EN 4'hE
`define IDX_IRQ_STAT 4'hF
`define IDX_IRQ_MASK 5'h10

`define CFG_CONFIGURE 0
`define CFG_FORCE_ERR 1
`define CFG_TMO_LSB 2
`define CFG_TMO_MSB 4
`define CFG_HOLD_LAST 5
`define STAT_HW_ERR 8
`define STAT_FIELD_FAIL 14
`define SMART_LSB 8

`define CFG_RESET 6'h00
`define TMO_MS_16S 16000
`define TMO_MS_4S 4000
`define TMO_MS_2S 2000
`define TMO_MS_1S 1000
`define TMO_MS_500 500
`define TMO_MS_250 250
`define TMO_MS_125 125
`define TMO_MS_62 62
`define CLK_MHZ 200
`define MS_TICK_CYCLES (`CLK_MHZ * 1000)

// interrupt status bits
`define IRQ_TIMEOUT 0
`define IRQ_OPEN_LOOP 1
`define IRQ_HW_ERR 2
`define IRQ_FIELD_FAIL 3
`define IRQ_WIDTH 4

`endif

// file: rtl/cur_out_pkg.sv
package cur_out_pkg;
    typedef logic [15:0] word_t;
    typedef logic [2:0] tmo_sel_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_e;
endpackage

// file: rtl/comm_timeout.sv
`timescale 1ns/1ps
`include "cur_out_defs.svh"

// watchdog: restarts on every kick, one pulse on expiry, then waits for a kick
module comm_timeout #(
    parameter int MS_CYCLES = `MS_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic kick,
    input wire cur_out_pkg::tmo_sel_t sel,
    output logic expired
);
    import cur_out_pkg::*;

    // a zero divider would never tick
    if (MS_CYCLES < 1) begin
        $error("MS_CYCLES must be at least one");
    end

    function automatic logic [13:0] period_ms(input tmo_sel_t s);
        case (s)
            3'h0: period_ms = 14'(`TMO_MS_16S);
            3'h1: period_ms = 14'(`TMO_MS_4S);
            3'h2: period_ms = 14'(`TMO_MS_2S);
            3'h3: period_ms = 14'(`TMO_MS_1S);
            3'h4: period_ms = 14'(`TMO_MS_500);
            3'h5: period_ms = 14'(`TMO_MS_250);
            3'h6: period_ms = 14'(`TMO_MS_125);
            default: period_ms = 14'(`TMO_MS_62);
        endcase
    endfunction

    logic [31:0] pre;
    logic [13:0] ms;
    logic armed;
    wire tick = (pre == 32'(MS_CYCLES - 1));
    wire hit = armed && tick && (ms + 14'h1 >= period_ms(sel));

    // ------------------------------------------------------------
    // millisecond divider and period counter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre <= 32'h0;
            ms <= 14'h0;
            armed <= 1'b1;
            expired <= 1'b0;
        end else begin
            expired <= hit && !kick;
            if (kick || tick) begin
                pre <= 32'h0;
            end else begin
                pre <= pre + 32'h1;
            end
            if (kick) begin
                ms <= 14'h0;
                armed <= 1'b1;
            end else if (hit) begin
                ms <= 14'h0;
                armed <= 1'b0;
            end else if (tick && armed) begin
                ms <= ms + 14'h1;
            end
        end
    end

    chk_expiry_after_tick: assert property (@(posedge ref_clk) disable iff (rst)
        expired |-> $past(tick) && !$past(kick))
        else $error("timeout fired without a tick");
endmodule

// file: rtl/cur_out_regs.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "cur_out_defs.svh"

// Operation
// - word 13 writes config, reads status
// - bit 0 configures; reads back configured
// - unconfigured: words 0-11 answer attention
// - bit 1 forces error and lights indicator
// - bits 2-4 pick timeout 16 s to 62 ms
// - timeout defaults to 16 s after reset
// - timeout may deviate up to 35 percent
// - bit 5 set: hold last value on timeout
// - bit 5 clear: zero all DACs on timeout
// - bit 8 reports any hardware diagnostic failure
// - word 12 bits 0-7 show open loops
// - word 14 bits 8-15 mark smart devices
module cur_out_regs #(
    parameter int MS_CYCLES = `MS_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [6:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic fpga_load_fail,
    input wire logic ee_csum_bad,
    input wire logic prom_csum_bad,
    input wire logic ram_diag_fail,
    input wire logic field_power_lost,
    input wire logic [7:0] open_loop,
    output logic module_configured,
    output logic internal_error_led,
    output logic hold_last_value,
    output logic zero_dacs,
    output logic [7:0] smart_enable,
    output logic irq
);
    import cur_out_pkg::*;

    // refused at elaboration: the divider needs at least one cycle per tick
    if (MS_CYCLES < 1) begin
        $error("MS_CYCLES must be at least one");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [12:0] sync1;
    logic [12:0] sync2;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1 <= 13'h0;
            sync2 <= 13'h0;
        end else begin
            sync1 <= {field_power_lost, ram_diag_fail, prom_csum_bad, ee_csum_bad, fpga_load_fail, open_loop};
            sync2 <= sync1;
        end
    end
    wire [7:0] loop_s = sync2[7:0];
    wire hw_err_s = |sync2[11:8];
    wire field_s = sync2[12];

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [5:0] cfg;
    logic [7:0] smart;
    logic [`IRQ_WIDTH-1:0] irq_stat;
    logic [`IRQ_WIDTH-1:0] irq_mask;
    logic [7:0] loop_q;
    logic hw_q;
    logic field_q;
    bus_state_e bus_state;

    wire [4:0] idx = wb_adr_i[6:2];
    wire req = wb_cyc_i && wb_stb_i && (bus_state == BUS_IDLE);
    wire lo_en = wb_sel_i[0];
    wire hi_en = wb_sel_i[1];
    wire hit_chan = (idx <= 5'(`IDX_CHAN_LAST));
    wire hit_loop = (idx == 5'(`IDX_OPEN_LOOP));
    wire hit_cfg = (idx == 5'(`IDX_CFG_STAT));
    wire hit_smart = (idx == 5'(`IDX_SMART_EN));
    wire hit_istat = (idx == 5'(`IDX_IRQ_STAT));
    wire hit_imask = (idx == 5'(`IDX_IRQ_MASK));
    wire mapped = hit_loop || hit_cfg || hit_smart || hit_istat || hit_imask;
    wire attention = hit_chan && !cfg[`CFG_CONFIGURE];
    wire good = req && mapped;
    wire bad = req && !mapped && !(hit_chan && cfg[`CFG_CONFIGURE]);
    wire wr_cfg = good && wb_we_i && hit_cfg && lo_en;
    wire wr_smart = good && wb_we_i && hit_smart && hi_en;
    wire wr_mask = good && wb_we_i && hit_imask && lo_en;
    wire rd_istat = good && !wb_we_i && hit_istat;
    // channel words belong to the datapath; once configured they count as access here
    wire valid_access = req && (mapped || (hit_chan && cfg[`CFG_CONFIGURE]));

    wire [15:0] status_word = {1'b0, field_q, 5'h0, hw_q, 6'h0,
                               cfg[`CFG_FORCE_ERR], cfg[`CFG_CONFIGURE]};
    wire [15:0] rd_word = hit_loop ? {8'h00, loop_q} :
                          hit_cfg ? status_word :
                          hit_istat ? {12'h000, irq_stat} :
                          hit_imask ? {12'h000, irq_mask} : 16'h0000;

    // ------------------------------------------------------------
    // communication timeout
    // ------------------------------------------------------------
    logic expired;
    logic timed_out;
    // nominal divider from the clock is exact, well inside the 35 percent window
    comm_timeout #(.MS_CYCLES(MS_CYCLES)) u_tmo (
        .ref_clk(ref_clk),
        .rst(rst),
        .kick(valid_access),
        .sel(cfg[`CFG_TMO_MSB:`CFG_TMO_LSB]),
        .expired(expired)
    );

    wire [`IRQ_WIDTH-1:0] irq_set = {field_s & ~field_q, hw_err_s & ~hw_q, |(loop_s & ~loop_q), expired};

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg <= `CFG_RESET;
            smart <= 8'h00;
            irq_mask <= '0;
            irq_stat <= '0;
            loop_q <= 8'h00;
            hw_q <= 1'b0;
            field_q <= 1'b0;
            timed_out <= 1'b0;
        end else begin
            loop_q <= loop_s;
            hw_q <= hw_err_s;
            field_q <= field_s;
            if (wr_cfg) begin
                cfg <= wb_dat_i[5:0]; // bits 6-7 are not stored
            end
            if (wr_smart) begin
                smart <= wb_dat_i[15:8];
            end
            if (wr_mask) begin
                irq_mask <= wb_dat_i[`IRQ_WIDTH-1:0];
            end
            // a new event in the clearing cycle survives
            irq_stat <= (rd_istat ? '0 : irq_stat) | irq_set;
            if (valid_access) begin
                timed_out <= 1'b0;
            end else if (expired) begin
                timed_out <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // bus answer and outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_state <= BUS_IDLE;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0;
            module_configured <= 1'b0;
            internal_error_led <= 1'b0;
            hold_last_value <= 1'b0;
            zero_dacs <= 1'b0;
            smart_enable <= 8'h00;
            irq <= 1'b0;
        end else begin
            bus_state <= req ? BUS_ACK : BUS_IDLE;
            wb_ack_o <= good;
            wb_err_o <= bad || (req && attention);
            wb_dat_o <= (good && !wb_we_i) ? {16'h0000, rd_word} : 32'h0;
            module_configured <= cfg[`CFG_CONFIGURE];
            internal_error_led <= cfg[`CFG_FORCE_ERR] || hw_q || timed_out;
            hold_last_value <= timed_out && cfg[`CFG_HOLD_LAST];
            zero_dacs <= timed_out && !cfg[`CFG_HOLD_LAST];
            smart_enable <= smart;
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence cfg_write_s;
        wr_cfg;
    endsequence

    chk_cfg_readback: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_write_s ##1 1'b1 |-> ##1 module_configured == $past(wb_dat_i[0], 2))
        else $error("configured bit does not follow write");
    chk_unconf_attention: assert property (@(posedge ref_clk) disable iff (rst)
        req && hit_chan && !cfg[0] |=> wb_err_o && !wb_ack_o)
        else $error("channel access while unconfigured not flagged");
    chk_force_error_led: assert property (@(posedge ref_clk) disable iff (rst)
        cfg[`CFG_FORCE_ERR] |=> internal_error_led)
        else $error("forced error did not light indicator");
    chk_hold_vs_zero: assert property (@(posedge ref_clk) disable iff (rst)
        !(hold_last_value && zero_dacs))
        else $error("hold and zero both active");
    chk_zero_on_timeout: assert property (@(posedge ref_clk) disable iff (rst)
        expired && !valid_access && !cfg[`CFG_HOLD_LAST] && !wr_cfg |=> ##1 zero_dacs)
        else $error("timeout with bit 5 clear did not zero outputs");
    chk_status_reserved: assert property (@(posedge ref_clk) disable iff (rst)
        wb_ack_o && $past(hit_cfg && !wb_we_i) |-> wb_dat_o[13:9] == 5'h0 && wb_dat_o[15] == 1'b0)
        else $error("reserved status bits not zero");
    chk_open_loop_read: assert property (@(posedge ref_clk) disable iff (rst)
        wb_ack_o && $past(hit_loop && !wb_we_i) |-> wb_dat_o[31:8] == 24'h0)
        else $error("open loop word has stray bits");
    chk_smart_write: assert property (@(posedge ref_clk) disable iff (rst)
        wr_smart |=> ##1 smart_enable == $past(wb_dat_i[15:8], 2))
        else $error("smart enable not stored");
    chk_ack_one_cycle: assert property (@(posedge ref_clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // read requests as taken; the answer stands one edge later
    sequence status_read_s;
        req && hit_cfg && !wb_we_i;
    endsequence

    sequence loop_read_s;
        req && hit_loop && !wb_we_i;
    endsequence

    sequence smart_read_s;
        req && hit_smart && !wb_we_i;
    endsequence

    sequence valid_access_s;
        valid_access;
    endsequence

    chk_default_timeout: assert property (@(posedge ref_clk)
        $fell(rst) |-> cfg[`CFG_TMO_MSB:`CFG_TMO_LSB] == 3'h0)
        else $error("timeout select not at default after reset");
    chk_status_configured: assert property (@(posedge ref_clk) disable iff (rst)
        status_read_s |=> wb_ack_o && wb_dat_o[0] == module_configured)
        else $error("status bit 0 disagrees with configured output");
    chk_status_forced: assert property (@(posedge ref_clk) disable iff (rst)
        status_read_s |=> wb_dat_o[1] == $past(cfg[`CFG_FORCE_ERR]))
        else $error("status bit 1 disagrees with forced error");
    chk_status_hw_err: assert property (@(posedge ref_clk) disable iff (rst)
        status_read_s |=> wb_dat_o[8] == $past(hw_q))
        else $error("status bit 8 disagrees with hardware error");
    chk_status_field: assert property (@(posedge ref_clk) disable iff (rst)
        status_read_s |=> wb_dat_o[14] == $past(field_q))
        else $error("status bit 14 disagrees with field power");
    chk_open_loop_value: assert property (@(posedge ref_clk) disable iff (rst)
        loop_read_s |=> wb_ack_o && wb_dat_o[7:0] == $past(loop_q))
        else $error("open loop flags not returned");
    chk_smart_read_zero: assert property (@(posedge ref_clk) disable iff (rst)
        smart_read_s |=> wb_ack_o && wb_dat_o == 32'h0)
        else $error("smart enable word read is not zero");
    chk_cfg_acked: assert property (@(posedge ref_clk) disable iff (rst)
        req && hit_cfg |=> wb_ack_o && !wb_err_o)
        else $error("config word access not acknowledged");
    chk_unmapped_err: assert property (@(posedge ref_clk) disable iff (rst)
        req && !mapped && !hit_chan |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    chk_ack_err_excl: assert property (@(posedge ref_clk) disable iff (rst)
        !(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    chk_err_one_cycle: assert property (@(posedge ref_clk) disable iff (rst)
        wb_err_o |=> !wb_err_o)
        else $error("err held longer than one cycle");
    chk_conf_chan_silent: assert property (@(posedge ref_clk) disable iff (rst)
        req && hit_chan && cfg[`CFG_CONFIGURE] |=> !wb_ack_o && !wb_err_o)
        else $error("configured channel word answered here");
    chk_hold_on_timeout: assert property (@(posedge ref_clk) disable iff (rst)
        expired && !valid_access && cfg[`CFG_HOLD_LAST] && !wr_cfg |=> ##1 hold_last_value)
        else $error("timeout with bit 5 set did not hold outputs");
    chk_restart_clears: assert property (@(posedge ref_clk) disable iff (rst)
        valid_access_s |=> !expired ##1 !hold_last_value && !zero_dacs)
        else $error("valid access did not restart the timeout");
endmodule

// file: tb/wb_ctrl.sv
`timescale 1ns/1ps
// ----------------------------------------
// controller side: one classic cycle per call
// ----------------------------------------
module wb_ctrl (
    input wire logic ref_clk,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [6:0] adr,
    output logic [3:0] sel,
    output logic [31:0] dat_w,
    input wire logic [31:0] dat_r,
    input wire logic ack,
    input wire logic err
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 7'h00;
        sel = 4'h0;
        dat_w = 32'h0;
    end
    // the answer is taken at the rising edge that samples ack or err, or after 40 edges without either; then the request is dropped
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] d,
            output logic [31:0] q, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        sel <= 4'hF;
        dat_w <= {16'h0000, (a[6:2] == 5'h0D) ? (d & 16'hFF3F) : d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
        q = dat_r;
        r = {err, ack};
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        // released lines must not keep looking valid
        adr <= ~a;
        dat_w <= ~dat_w;
    endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    import cur_out_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc, wb_stb, wb_we, wb_ack, wb_err;
    logic [6:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, q;
    logic [3:0] hw_fail = 4'h0;
    logic field_lost = 1'b0;
    logic [7:0] open_loop = 8'h00;
    logic configured, err_led, hold, zero, irq;
    logic [7:0] smart;
    int bad_count = 0;
    int total_checks = 0;
    int ms[8] = '{16000, 4000, 2000, 1000, 500, 250, 125, 62};
    always #2.5 ref_clk = ~ref_clk;
    wb_ctrl wb_ctrl_i (.ref_clk(ref_clk), .cyc(wb_cyc), .stb(wb_stb), .we(wb_we), .adr(wb_adr),
        .sel(wb_sel), .dat_w(wb_dat_w), .dat_r(wb_dat_r), .ack(wb_ack), .err(wb_err));
    cur_out_regs #(.MS_CYCLES(2)) cur_out_regs_i (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .wb_err_o(wb_err), .fpga_load_fail(hw_fail[0]),
        .ee_csum_bad(hw_fail[1]), .prom_csum_bad(hw_fail[2]), .ram_diag_fail(hw_fail[3]),
        .field_power_lost(field_lost), .open_loop(open_loop), .module_configured(configured),
        .internal_error_led(err_led), .hold_last_value(hold), .zero_dacs(zero),
        .smart_enable(smart), .irq(irq));
    // ----------------------------------------
    // checking and bus helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(input logic wr, input logic [6:0] a, input logic [15:0] d, input logic [1:0] rx);
        logic [1:0] r;
        wb_ctrl_i.xfer(wr, a, d, q, r);
        chk("bus response", 32'(r), 32'(rx));
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_unconfigured;
        chk("outputs at reset", 32'({configured, err_led, hold, zero, irq, smart}), 32'h0);
        acc(1'b0, 7'h34, 16'h0, 2'b01);
        chk("status at reset", q, 32'h0);
        foreach (ms[i]) acc(i[0], 7'(i * 6 / 4 * 4), 16'h1234, 2'b10);
        acc(1'b0, 7'h44, 16'h0, 2'b10);
        acc(1'b1, 7'h30, 16'hFFFF, 2'b01);
    endtask
    task automatic t_config;
        // outputs follow the register one edge after the ack edge
        acc(1'b1, 7'h34, 16'h00C1, 2'b01);
        @(posedge ref_clk);
        chk("configured", 32'(configured), 32'h1);
        acc(1'b0, 7'h34, 16'h0, 2'b01);
        chk("status configured", q, 32'h0001);
        acc(1'b1, 7'h34, 16'h0003, 2'b01);
        @(posedge ref_clk);
        chk("error led", 32'(err_led), 32'h1);
        acc(1'b0, 7'h34, 16'h0, 2'b01);
        chk("status forced", q, 32'h0003);
        acc(1'b1, 7'h34, 16'h0001, 2'b01);
        @(posedge ref_clk);
        chk("error led off", 32'(err_led), 32'h0);
    endtask
    task automatic t_diag;
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            hw_fail <= (i < 4) ? 4'(1 << i) : 4'h0;
            field_lost <= (i == 4);
            repeat (4) @(posedge ref_clk);
            acc(1'b0, 7'h34, 16'h0, 2'b01);
            chk("status diag", q, (i < 4) ? 32'h0101 : 32'h4001);
        end
        @(posedge ref_clk);
        field_lost <= 1'b0;
        open_loop <= 8'hA5;
        repeat (4) @(posedge ref_clk);
        acc(1'b0, 7'h30, 16'h0, 2'b01);
        chk("open loop", q, 32'h00A5);
        acc(1'b1, 7'h38, 16'h5AFF, 2'b01);
        @(posedge ref_clk);
        chk("smart enable", 32'(smart), 32'h5A);
        acc(1'b0, 7'h38, 16'h0, 2'b01);
        chk("smart read", q, 32'h0);
        acc(1'b1, 7'h38, 16'h0000, 2'b01);
        @(posedge ref_clk);
        chk("smart cleared", 32'(smart), 32'h0);
    endtask
    task automatic t_timeout;
        int nom, n, code;
        acc(1'b1, 7'h40, 16'h0000, 2'b01);
        // the hold case reuses the shortest period to keep the run short
        for (int c = 0; c < 9; c++) begin
            code = (c < 8) ? c : 7;
            nom = 2 * ms[code];
            acc(1'b1, 7'h34, 16'(1 | code << 2 | (c / 8) << 5), 2'b01);
            repeat (nom / 2) @(posedge ref_clk);
            acc(1'b0, 7'h34, 16'h0, 2'b01);
            n = 0;
            while ((c < 8 ? zero : hold) !== 1'b1 && n < 2 * nom) begin
                @(posedge ref_clk);
                n++;
            end
            chk("timeout window", 32'(n >= nom * 65 / 100 && n <= nom * 135 / 100 + 4), 32'h1);
            chk("action", 32'({hold, zero}), (c < 8) ? 32'h1 : 32'h2);
            chk("masked irq", 32'(irq), 32'h0);
        end
        acc(1'b1, 7'h40, 16'h0001, 2'b01);
        repeat (2) @(posedge ref_clk);
        chk("irq raised", 32'(irq), 32'h1);
        acc(1'b0, 7'h3C, 16'h0, 2'b01);
        chk("irq status", q & 32'h1, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", 32'(irq), 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_unconfigured();
        t_config();
        t_diag();
        t_timeout();
        wrap_up();
    end
    // runs are about 72k cycles; this allows for slack
    initial begin
        #450000;
        bad_count++;
        wrap_up();
    end
endmodule
